// ---- design/rlb_defs.vh ----
/*
 * rlb_defs.vh: constants for the remote/local bus responder.
 * assumes: included by bare name from design files; definitions only.
 */
`ifndef RLB_DEFS_VH
`define RLB_DEFS_VH

// ==========================================================
// multi-line bus command codes (7-bit, attention asserted)
`define RLB_CMD_GTL 7'h01
`define RLB_CMD_SDC 7'h04
`define RLB_CMD_PPC 7'h05
`define RLB_CMD_GET 7'h08
`define RLB_CMD_TCT 7'h09
`define RLB_CMD_LLO 7'h11
`define RLB_CMD_DCL 7'h14
`define RLB_CMD_PPU 7'h15
`define RLB_CMD_SPE 7'h18
`define RLB_CMD_SPD 7'h19
`define RLB_CMD_UNL 7'h3f
`define RLB_CMD_UNT 7'h5f

// ==========================================================
// address groups: bits 6:5 select listen or talk group
`define RLB_GRP_LSB 5
`define RLB_GRP_LISTEN 2'h1
`define RLB_GRP_TALK 2'h2
`define RLB_ADDR_MAX 5'h1e

// ==========================================================
// command type encoding and remote/local state codes
`define RLB_TYPE_STANDARD 1'h0
`define RLB_TYPE_LEGACY 1'h1
`define RLB_ST_LOCAL 2'h0
`define RLB_ST_REMOTE 2'h1
`define RLB_ST_REMOTE_LOCK 2'h2
`define RLB_ST_LOCAL_LOCK 2'h3

`endif

// ---- design/rlb_edge.v ----
/*
 * rlb_edge.v: rising-edge detector for one synchronous level.
 * assumes: input already synchronous to ref_clk.
 */
`timescale 1ns/100ps
`include "rlb_defs.vh"

module rlb_edge (
    // clock and reset
    input wire ref_clk,
    input wire rst_b,
    // level in, pulse out
    input wire level_in,
    output wire rise_out
);

reg level_q;

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        level_q <= 1'b0;
    end else begin
        level_q <= level_in;
    end
end

assign rise_out = level_in & ~level_q;

endmodule // rlb_edge

// ---- design/rlb_responder.v ----
/*
 * rlb_responder.v: remote/local decision and interface message
 * responder for an instrument on a parallel bus and a network link.
 * assumes: all inputs synchronous to ref_clk; bus byte decode,
 * handshake and network parsing are done outside and presented
 * as one-cycle strobes.
 */
// Functional notes
// - IFC drops addressing, aborts transmission
// - REN line moves remote and local
// - IDY gets no response at all
// - GTL when listening enters local
// - SDC discards input, empties output queue
// - device clear cancels OPC, aborts waits
// - PPC and TCT are ignored
// - GET in legacy mode reports status
// - lockout blocks front-panel return to local
// - DCL acts like SDC, unaddressed
// - address commands need listen addressing
// - SPE puts talker into serial poll
// - SPD returns talker to normal output
// - PPU is ignored
// - network remote ON enters remote
// - remote disables panel except local flip
// - mode changes keep settings untouched
// - local flip returns local unless locked
// - network remote OFF gives local, except from local, where a REN rise, listen address, remote ON or lockout (LLO or lockout ON) wins
// - remote lamp follows remote operation
// - command type latched once after each reset release
// - own address 0..30, answer only it
`timescale 1ns/100ps
`include "rlb_defs.vh"

module rlb_responder #(
    parameter ADDR_W = 5
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_b,
    // configuration
    input wire [ADDR_W-1:0] bus_addr,
    input wire cmd_type_sel,
    // parallel bus uni-line messages
    input wire ifc_in,
    input wire ren_in,
    input wire idy_in,
    // parallel bus multi-line command strobe
    input wire bus_cmd_valid,
    input wire [6:0] bus_cmd_code,
    // network link commands
    input wire net_remote_on,
    input wire net_remote_off,
    input wire net_lockout_on,
    input wire net_lockout_off,
    input wire std_cmd_valid,
    // front panel
    input wire output_toggle_switch,
    input wire panel_req,
    // talker state from the data path
    input wire tx_busy,
    // addressing and mode status
    output wire listen_addressed,
    output wire talk_addressed,
    output wire serial_poll_mode,
    output wire remote_lamp,
    output wire lockout_active,
    output wire legacy_active,
    output wire addr_valid,
    // clear and event pulses
    output reg tx_abort,
    output reg input_discard,
    output reg output_queue_flush,
    output reg opc_cancel,
    output reg wait_abort,
    output reg trigger_report,
    output reg std_cmd_reject,
    // front panel gate
    output wire panel_enable,
    output wire panel_local_accept,
    // network link gate
    output wire net_link_enable
);

// ==========================================================
// state
reg [1:0] rl_state_q;
reg [1:0] rl_state_d;
reg lad_q;
reg lad_d;
reg tad_q;
reg tad_d;
reg spm_q;
reg spm_d;
reg legacy_q;
reg type_taken_q;
reg ren_q;

wire sw_rise;
wire ren_fall;
wire ren_rise;
wire is_remote;
wire is_locked;
wire my_listen;
wire my_talk;
wire addr_ok;
wire cmd_gtl;
wire cmd_sdc;
wire cmd_get;
wire cmd_llo;
wire cmd_dcl;
wire cmd_spe;
wire cmd_spd;
wire dev_clear;
wire net_ok;

// ==========================================================
// decode
assign addr_ok = (bus_addr <= `RLB_ADDR_MAX);
assign my_listen = bus_cmd_valid & addr_ok
    & (bus_cmd_code[6:`RLB_GRP_LSB] == `RLB_GRP_LISTEN)
    & (bus_cmd_code[4:0] == bus_addr);
assign my_talk = bus_cmd_valid & addr_ok
    & (bus_cmd_code[6:`RLB_GRP_LSB] == `RLB_GRP_TALK)
    & (bus_cmd_code[4:0] == bus_addr);
// only commands from the list below, plus UNL/UNT in the addressing block, act; PPC, TCT, PPU fall out
assign cmd_gtl = bus_cmd_valid & lad_q & (bus_cmd_code == `RLB_CMD_GTL);
assign cmd_sdc = bus_cmd_valid & lad_q & (bus_cmd_code == `RLB_CMD_SDC);
assign cmd_get = bus_cmd_valid & lad_q & (bus_cmd_code == `RLB_CMD_GET);
assign cmd_llo = bus_cmd_valid & (bus_cmd_code == `RLB_CMD_LLO);
assign cmd_dcl = bus_cmd_valid & (bus_cmd_code == `RLB_CMD_DCL);
assign cmd_spe = bus_cmd_valid & (bus_cmd_code == `RLB_CMD_SPE);
assign cmd_spd = bus_cmd_valid & (bus_cmd_code == `RLB_CMD_SPD);
// PPC/TCT/PPU and idy_in are deliberately not decoded
assign dev_clear = cmd_sdc | cmd_dcl;
// legacy mode shuts the network path entirely
assign net_ok = ~legacy_q;

// ==========================================================
// edge detection on the front switch and the remote enable line
rlb_edge u_sw_edge (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .level_in(output_toggle_switch),
    .rise_out(sw_rise)
);

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        ren_q <= 1'b0;
    end else begin
        ren_q <= ren_in;
    end
end

assign ren_fall = ren_q & ~ren_in;
assign ren_rise = ren_in & ~ren_q;

// ==========================================================
// command type is caught once after reset release
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        legacy_q <= `RLB_TYPE_STANDARD;
        type_taken_q <= 1'b0;
    end else if (!type_taken_q) begin
        legacy_q <= cmd_type_sel;
        type_taken_q <= 1'b1;
    end
end

// ==========================================================
// addressing and serial poll
always @* begin
    lad_d = lad_q;
    tad_d = tad_q;
    spm_d = spm_q;
    if (bus_cmd_valid) begin
        if (bus_cmd_code == `RLB_CMD_UNL) begin
            lad_d = 1'b0;
        end
        if (bus_cmd_code == `RLB_CMD_UNT) begin
            tad_d = 1'b0;
        end
        if (my_listen) begin
            lad_d = 1'b1;
            tad_d = 1'b0;
        end
        if (my_talk) begin
            tad_d = 1'b1;
            lad_d = 1'b0;
        end
        if (cmd_spe) begin
            spm_d = 1'b1;
        end
        if (cmd_spd) begin
            spm_d = 1'b0;
        end
    end
    if (ifc_in) begin
        lad_d = 1'b0;
        tad_d = 1'b0;
        spm_d = 1'b0;
    end
end

// ==========================================================
// remote/local state; settings live outside and are never touched
always @* begin
    rl_state_d = rl_state_q;
    case (rl_state_q)
    `RLB_ST_LOCAL: begin
        if (ren_in & ~ren_rise & my_listen) begin
            rl_state_d = cmd_llo ? `RLB_ST_REMOTE_LOCK : `RLB_ST_REMOTE;
        end else if (ren_rise) begin
            rl_state_d = `RLB_ST_REMOTE;
        end else if (net_ok & net_remote_on) begin
            rl_state_d = net_lockout_on ? `RLB_ST_REMOTE_LOCK : `RLB_ST_REMOTE;
        end else if ((ren_in & cmd_llo) | (net_ok & net_lockout_on)) begin
            rl_state_d = `RLB_ST_LOCAL_LOCK;
        end
    end
    `RLB_ST_REMOTE: begin
        if (cmd_gtl | (sw_rise & ~cmd_llo)) begin
            rl_state_d = `RLB_ST_LOCAL;
        end else if ((ren_in & cmd_llo) | (net_ok & net_lockout_on)) begin
            rl_state_d = `RLB_ST_REMOTE_LOCK;
        end
        if (net_ok & net_remote_off) begin
            rl_state_d = `RLB_ST_LOCAL;
        end
    end
    `RLB_ST_REMOTE_LOCK: begin
        // panel switch has no effect here
        if (cmd_gtl) begin
            rl_state_d = `RLB_ST_LOCAL_LOCK;
        end else if (net_ok & net_lockout_off) begin
            rl_state_d = `RLB_ST_REMOTE;
        end
        if (net_ok & net_remote_off) begin
            rl_state_d = `RLB_ST_LOCAL;
        end
    end
    `RLB_ST_LOCAL_LOCK: begin
        if ((ren_in & my_listen) | ren_rise) begin
            rl_state_d = `RLB_ST_REMOTE_LOCK;
        end else if (net_ok & net_remote_on) begin
            rl_state_d = `RLB_ST_REMOTE_LOCK;
        end else if (net_ok & net_lockout_off) begin
            rl_state_d = `RLB_ST_LOCAL;
        end
        // remote off also drops a lockout taken while local
        if (net_ok & net_remote_off) begin
            rl_state_d = `RLB_ST_LOCAL;
        end
    end
    default: begin
        rl_state_d = `RLB_ST_LOCAL;
    end
    endcase
    if (ren_fall) begin
        rl_state_d = `RLB_ST_LOCAL;
    end
end

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        rl_state_q <= `RLB_ST_LOCAL;
        lad_q <= 1'b0;
        tad_q <= 1'b0;
        spm_q <= 1'b0;
    end else begin
        rl_state_q <= rl_state_d;
        lad_q <= lad_d;
        tad_q <= tad_d;
        spm_q <= spm_d;
    end
end

// ==========================================================
// one-cycle action pulses, registered
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        tx_abort <= 1'b0;
        input_discard <= 1'b0;
        output_queue_flush <= 1'b0;
        opc_cancel <= 1'b0;
        wait_abort <= 1'b0;
        trigger_report <= 1'b0;
        std_cmd_reject <= 1'b0;
    end else begin
        tx_abort <= ifc_in & tx_busy;
        input_discard <= dev_clear;
        output_queue_flush <= dev_clear;
        opc_cancel <= dev_clear;
        wait_abort <= dev_clear;
        trigger_report <= cmd_get & legacy_q;
        std_cmd_reject <= std_cmd_valid & legacy_q;
    end
end

// ==========================================================
// status outputs
assign is_remote = (rl_state_q == `RLB_ST_REMOTE) | (rl_state_q == `RLB_ST_REMOTE_LOCK);
assign is_locked = (rl_state_q == `RLB_ST_REMOTE_LOCK) | (rl_state_q == `RLB_ST_LOCAL_LOCK);
assign listen_addressed = lad_q;
assign talk_addressed = tad_q;
assign serial_poll_mode = spm_q;
assign remote_lamp = is_remote;
assign lockout_active = is_locked;
assign legacy_active = legacy_q;
assign addr_valid = addr_ok;
// panel_req is only meaningful while local; the gate goes to the panel
assign panel_enable = ~is_remote & panel_req;
assign panel_local_accept = (rl_state_q == `RLB_ST_REMOTE) & sw_rise;
assign net_link_enable = net_ok;

endmodule // rlb_responder

// ---- test/rlb_ctl_model.sv ----
/* rlb_ctl_model.sv: bus controller model sending command bytes.
   assumes: ref_clk runs free; nothing else talks to the device. */
`timescale 1ns/100ps
// ========
// controller model
module rlb_ctl_model (
    // clock
    input wire ref_clk,
    // command byte strobe
    output reg bus_cmd_valid,
    output reg [6:0] bus_cmd_code
);
    initial begin
        bus_cmd_valid = 1'b0;
        bus_cmd_code = 7'h00;
    end
    // one byte per call and one interface in use at a time
    task send(input [6:0] code);
        begin
            @(posedge ref_clk);
            #1;
            bus_cmd_valid = 1'b1;
            bus_cmd_code = code;
            @(posedge ref_clk);
            #1;
            bus_cmd_valid = 1'b0;
            // a released bus must not look like the last byte
            bus_cmd_code = ~code;
        end
    endtask
endmodule // rlb_ctl_model

// ---- test/rlb_responder_checker.sv ----
/* rlb_responder_checker.sv: port assertions for rlb_responder.
   assumes: bound to every rlb_responder; one clock, async low reset. */
`timescale 1ns/100ps
`include "rlb_defs.vh"
// ========
// checker
module rlb_responder_checker #(
    parameter ADDR_W = 5
) (
    // clock, reset, configuration
    input wire ref_clk,
    input wire rst_b,
    input wire [ADDR_W-1:0] bus_addr,
    // bus, link and panel inputs
    input wire ifc_in,
    input wire ren_in,
    input wire bus_cmd_valid,
    input wire [6:0] bus_cmd_code,
    input wire net_remote_off,
    input wire panel_req,
    // watched outputs
    input wire listen_addressed,
    input wire serial_poll_mode,
    input wire remote_lamp,
    input wire lockout_active,
    input wire legacy_active,
    input wire input_discard,
    input wire wait_abort,
    input wire panel_enable,
    input wire net_link_enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire cmd_ok = bus_cmd_valid && !ifc_in;
    sequence s_my_listen;
        cmd_ok && bus_cmd_code == (7'h20 | bus_addr) && bus_addr <= `RLB_ADDR_MAX;
    endsequence
    sequence s_sdc;
        cmd_ok && bus_cmd_code == `RLB_CMD_SDC;
    endsequence
    AST_IFC: assert property (ifc_in |=> !listen_addressed)
        else $error("listener kept after interface clear");
    AST_DCL: assert property (cmd_ok && bus_cmd_code == `RLB_CMD_DCL |=> input_discard && wait_abort)
        else $error("device clear gave no clear pulses");
    AST_SDC: assert property (s_my_listen ##1 s_sdc |=> input_discard)
        else $error("selected clear ignored while listening");
    AST_SPE: assert property (cmd_ok && bus_cmd_code == `RLB_CMD_SPE |=> serial_poll_mode)
        else $error("poll enable not taken");
    AST_SPD: assert property (bus_cmd_valid && bus_cmd_code == `RLB_CMD_SPD |=> !serial_poll_mode)
        else $error("poll disable not taken");
    AST_REN: assert property ($rose(ren_in) && !net_remote_off && !bus_cmd_valid |=> remote_lamp)
        else $error("remote enable did not light lamp");
    AST_NET_OFF: assert property (net_remote_off && !legacy_active && !$rose(ren_in)
        && !bus_cmd_valid |=> !remote_lamp && !lockout_active)
        else $error("remote off did not return local");
    AST_PANEL: assert property (panel_enable == (panel_req && !remote_lamp))
        else $error("panel gate wrong for mode");
    AST_LINK: assert property (net_link_enable == !legacy_active)
        else $error("network link gate wrong");
endmodule // rlb_responder_checker

bind rlb_responder rlb_responder_checker #(.ADDR_W(ADDR_W)) u_chk (.ref_clk, .rst_b,
    .bus_addr, .ifc_in, .ren_in, .bus_cmd_valid, .bus_cmd_code, .net_remote_off,
    .panel_req, .listen_addressed, .serial_poll_mode, .remote_lamp, .lockout_active,
    .legacy_active, .input_discard, .wait_abort, .panel_enable, .net_link_enable);

// ---- test/rlb_responder_tb.sv ----
/* rlb_responder_tb.sv: self-checking bench for rlb_responder.
   assumes: rlb_ctl_model drives the command strobe, the bench the rest. */
`timescale 1ns/100ps
`include "rlb_defs.vh"
// ========
// bench
module rlb_responder_tb;
    reg ref_clk, rst_b, cmd_type_sel, ifc_in, ren_in, idy_in, std_cmd_valid;
    reg net_remote_on, net_remote_off, net_lockout_on, net_lockout_off;
    reg output_toggle_switch, panel_req, tx_busy;
    reg [4:0] bus_addr;
    wire bus_cmd_valid, listen_addressed, talk_addressed, serial_poll_mode, remote_lamp;
    wire lockout_active, legacy_active, tx_abort, input_discard, output_queue_flush;
    wire opc_cancel, wait_abort, trigger_report, std_cmd_reject, panel_enable;
    wire net_link_enable, addr_valid, panel_local_accept;
    wire [6:0] bus_cmd_code;
    integer failures, checks_done, ls, tk, sp, rem, lk, lg, i, p;
    logic [6:0] tbl [10] = '{`RLB_CMD_GTL, `RLB_CMD_SDC, `RLB_CMD_PPC, `RLB_CMD_GET,
        `RLB_CMD_TCT, `RLB_CMD_LLO, `RLB_CMD_DCL, `RLB_CMD_PPU, `RLB_CMD_SPE, `RLB_CMD_SPD};
    rlb_ctl_model ctl (.ref_clk, .bus_cmd_valid, .bus_cmd_code);
    rlb_responder uut (.ref_clk, .rst_b, .bus_addr, .cmd_type_sel, .ifc_in, .ren_in,
        .idy_in, .bus_cmd_valid, .bus_cmd_code, .net_remote_on, .net_remote_off,
        .net_lockout_on, .net_lockout_off, .std_cmd_valid, .output_toggle_switch,
        .panel_req, .tx_busy, .listen_addressed, .talk_addressed, .serial_poll_mode,
        .remote_lamp, .lockout_active, .legacy_active, .addr_valid, .tx_abort,
        .input_discard, .output_queue_flush, .opc_cancel, .wait_abort, .trigger_report,
        .std_cmd_reject, .panel_enable, .panel_local_accept, .net_link_enable);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task final_report;
        begin
            if (failures == 0 && checks_done > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task step;
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    task st;
        chk({listen_addressed, talk_addressed, serial_poll_mode, remote_lamp, lockout_active},
            {ls[0], tk[0], sp[0], rem[0], lk[0]});
    endtask
    // bits: ifc, idy, std, remote on, remote off, lockout on, lockout off
    task pulse(input [6:0] v);
        begin
            step;
            {ifc_in, idy_in, std_cmd_valid, net_remote_on, net_remote_off, net_lockout_on,
                net_lockout_off} = v;
            step;
            {ifc_in, idy_in, std_cmd_valid, net_remote_on, net_remote_off, net_lockout_on,
                net_lockout_off} = 7'h00;
        end
    endtask
    task cmd(input [6:0] c);
        integer clr, trig;
        begin
            clr = (c == `RLB_CMD_DCL) || (c == `RLB_CMD_SDC && ls);
            trig = c == `RLB_CMD_GET && ls && lg;
            if (c == `RLB_CMD_GTL && ls) rem = 0;
            if (c == `RLB_CMD_LLO && ren_in) lk = 1;
            if (c == `RLB_CMD_SPE) sp = 1;
            if (c == `RLB_CMD_SPD) sp = 0;
            if (c == `RLB_CMD_UNL) ls = 0;
            if (c == `RLB_CMD_UNT) tk = 0;
            if (c == (7'h20 | bus_addr)) begin
                ls = 1;
                tk = 0;
                rem = rem | ren_in;
            end
            if (c == (7'h40 | bus_addr)) begin
                tk = 1;
                ls = 0;
            end
            ctl.send(c);
            st;
            chk({input_discard, output_queue_flush, opc_cancel, wait_abort, trigger_report},
                {{4{clr[0]}}, trig[0]});
        end
    endtask
    task do_reset(input t);
        begin
            cmd_type_sel = t;
            rst_b = 1'b0;
            repeat (8) step;
            rst_b = 1'b1;
            step;
            step;
            {ls, tk, sp, rem, lk, lg} = {0, 0, 0, 0, 0, 32'(t)};
            st;
            chk({legacy_active, net_link_enable}, {t, !t});
            chk(addr_valid, 1);
        end
    endtask
    initial begin
        #2000000;
        failures = failures + 1;
        final_report;
    end
    initial begin
        {failures, checks_done, ren_in, output_toggle_switch, panel_req, tx_busy} = 0;
        {ifc_in, idy_in, std_cmd_valid, net_remote_on, net_remote_off} = 5'h00;
        {net_lockout_on, net_lockout_off} = 2'h0;
        void'($urandom(32'h33ba7c9a));
        bus_addr = 5'($urandom % 31);
        do_reset(1'b0);
        for (p = 0; p < 2; p++) begin
            for (i = 0; i < 10; i++) cmd(tbl[i]);
            cmd(7'h20 | 7'((bus_addr + 1) % 31));
            if (p == 0) cmd(7'h20 | bus_addr);
        end
        cmd(`RLB_CMD_UNL);
        cmd(7'h40 | bus_addr);
        cmd(`RLB_CMD_SPE);
        cmd(`RLB_CMD_SPD);
        cmd(`RLB_CMD_UNT);
        panel_req = 1'b1;
        ren_in = 1'b1;
        step;
        rem = 1;
        st;
        chk(panel_enable, 0);
        output_toggle_switch = 1'b1;
        #1;
        chk(panel_local_accept, 1);
        step;
        rem = 0;
        st;
        chk(panel_enable, 1);
        {output_toggle_switch, ren_in} = 2'h0;
        step;
        ren_in = 1'b1;
        step;
        rem = 1;
        st;
        cmd(`RLB_CMD_LLO);
        output_toggle_switch = 1'b1;
        #1;
        chk(panel_local_accept, 0);
        step;
        st;
        output_toggle_switch = 1'b0;
        pulse(7'h04);
        {rem, lk} = 0;
        st;
        pulse(7'h08);
        rem = 1;
        st;
        pulse(7'h02);
        lk = 1;
        st;
        pulse(7'h01);
        lk = 0;
        st;
        cmd(7'h20 | bus_addr);
        cmd(`RLB_CMD_GTL);
        ren_in = 1'b0;
        tx_busy = 1'b1;
        pulse(7'h40);
        {ls, sp} = 0;
        st;
        chk(tx_abort, 1);
        tx_busy = 1'b0;
        pulse(7'h30);
        st;
        chk({tx_abort, input_discard, std_cmd_reject}, 0);
        do_reset(1'b1);
        cmd_type_sel = 1'b0;
        pulse(7'h18);
        st;
        chk({std_cmd_reject, legacy_active}, 3);
        cmd(7'h20 | bus_addr);
        // legacy GET here pulses trigger_report, checked inside cmd, so no settling pause
        cmd(`RLB_CMD_GET);
        final_report;
    end
endmodule // rlb_responder_tb
